// ==== design/atsm_led_latch.v ====
/*
  Per-channel sticky LED indication latches with restore load.
  Assumes synchronous inputs; clear comes from the register port, restore from the non-volatile record store.
*/
module atsm_led_latch #(
  parameter N = 15
) (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire [N-1:0] event_in,
  input wire clear_in,
  input wire load_in,
  input wire [N-1:0] load_data_in,
  output reg [N-1:0] led_out
);
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_led
      always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          led_out[i] <= 1'b0;
        end else if (load_in) begin
          led_out[i] <= load_data_in[i] | event_in[i];
        end else if (event_in[i]) begin
          led_out[i] <= 1'b1;
        end else if (clear_in) begin
          led_out[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// ==== design/atsm_nv_mem.v ====
/*
  Small non-volatile store for control, setup and LED records.
  Assumes the physical array retains contents without power; read data registered.
*/
module atsm_nv_mem #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire ref_clk_in,
  input wire wr_en_in,
  input wire [AW-1:0] addr_in,
  input wire [WIDTH-1:0] wr_data_in,
  output reg [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem[addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[addr_in];
  end
endmodule

// ==== design/atsm_regs.vh ====
/*
  Register map, field positions and reset values for the
  arc trip scheme matrix.
  Assumes a 32-bit register port with read data one cycle after the strobe.
*/
`ifndef ATSM_REGS_VH
`define ATSM_REGS_VH

`define ATSM_ADDR_W 4
`define ATSM_DATA_W 32

`define ATSM_REG_CTRL 4'h0
`define ATSM_REG_STATUS 4'h1
`define ATSM_REG_IRQ_STAT 4'h2
`define ATSM_REG_IRQ_MASK 4'h3
`define ATSM_REG_LED 4'h4
`define ATSM_REG_NV_CMD 4'h5
`define ATSM_REG_SETUP 4'h6

`define ATSM_CTRL_SCHEME_LSB 0
`define ATSM_CTRL_SCHEME_MSB 2
`define ATSM_CTRL_LIGHT_ONLY 3
`define ATSM_CTRL_BLOCK 4
`define ATSM_CTRL_RESET 5'h00

`define ATSM_SCHEME_0 3'h0
`define ATSM_SCHEME_1 3'h1
`define ATSM_SCHEME_2 3'h2
`define ATSM_SCHEME_3 3'h3
`define ATSM_SCHEME_4 3'h4

`define ATSM_IRQ_TRIP 0
`define ATSM_IRQ_LED 1
`define ATSM_IRQ_NV_DONE 2
`define ATSM_IRQ_W 3

`define ATSM_NV_SLOT_CTRL 2'h0
`define ATSM_NV_SLOT_SETUP 2'h1
`define ATSM_NV_SLOT_LED 2'h2

`define ATSM_NV_CMD_SAVE 0
`define ATSM_NV_CMD_LOAD 1

`endif

// ==== design/atsm_top.v ====
/*
  Arc trip scheme matrix: maps sensor channels, current sense and external
  trip onto trip relays and auxiliary outputs, with register port,
  interrupt and non-volatile record store.
  Assumes all inputs are synchronous to ref_clk_in.
*/
`include "atsm_regs.vh"

module atsm_top #(
  parameter N_CH = 15
) (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire [N_CH-1:0] sensor_in,
  input wire current_sense_input_in,
  input wire external_trip_input_in,
  input wire [`ATSM_ADDR_W-1:0] addr_in,
  input wire [`ATSM_DATA_W-1:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  output reg [`ATSM_DATA_W-1:0] rd_data_out,
  output reg trip_relay_1_out,
  output reg trip_relay_2_out,
  output reg trip_relay_3_out,
  output reg trip_relay_4_out,
  output reg high_speed_output_out,
  output reg fast_clear_output_out,
  output reg trip_indication_output_out,
  output reg irq_out
);
  ////////////////////////////////////////////////////////////////////////
  // Register state
  reg [4:0] ctrl;
  reg [31:0] setup;
  reg [`ATSM_IRQ_W-1:0] irq_stat;
  reg [`ATSM_IRQ_W-1:0] irq_mask;
  reg ind_clear;
  wire [2:0] scheme = ctrl[`ATSM_CTRL_SCHEME_MSB:`ATSM_CTRL_SCHEME_LSB];
  wire light_only = ctrl[`ATSM_CTRL_LIGHT_ONLY];
  wire blocking = ctrl[`ATSM_CTRL_BLOCK];
  wire [N_CH-1:0] led;

  function wr_hit;
    input [`ATSM_ADDR_W-1:0] a;
    input [`ATSM_ADDR_W-1:0] r;
    begin
      wr_hit = wr_en_in && (a == r);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Trip criterion
  // light with current, or light alone when light-only is set
  wire crit_ok = light_only | current_sense_input_in;
  wire [N_CH-1:0] light = sensor_in & {N_CH{crit_ok}};

  ////////////////////////////////////////////////////////////////////////
  // Scheme matrix
  reg [3:0] rel;
  reg high_speed_output;
  reg fcl;
  reg any_light;
  reg [N_CH-1:0] other_mask;
  always @* begin
    rel = 4'h0;
    high_speed_output = 1'b0;
    fcl = 1'b0;
    any_light = |light;
    other_mask = {N_CH{1'b1}};
    other_mask[10] = 1'b0;
    other_mask[11] = 1'b0;
    other_mask[12] = 1'b0;
    case (scheme)
      `ATSM_SCHEME_3: begin
        rel[0] = light[10];
        rel[1] = light[11];
        rel[2] = light[12];
        rel[3] = |(light & other_mask);
        high_speed_output = rel[3];
        fcl = 1'b0;
      end
      `ATSM_SCHEME_4: begin
        other_mask[13] = 1'b0;
        rel = {4{|(light & other_mask)}};
        rel = rel | {light[13], light[12], light[11], light[10]};
        high_speed_output = |(light & other_mask);
        fcl = 1'b0;
      end
      `ATSM_SCHEME_2: begin
        rel[0] = any_light;
        rel[1] = light[0] | light[1];
        rel[2] = |light[N_CH-1:2];
        rel[3] = light[13];
        high_speed_output = any_light;
        fcl = |(light & ~15'h0013);
      end
      `ATSM_SCHEME_1: begin
        rel = {4{any_light}};
        high_speed_output = any_light;
        fcl = |(light & ~15'h0013);
      end
      `ATSM_SCHEME_0: begin
        rel = {4{any_light}};
        high_speed_output = any_light;
        fcl = |(light & ~15'h0010);
      end
      default: begin
        rel = 4'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Output stage
  // external trip all four relays
  wire [3:0] next_rel = blocking ? 4'h0 : (rel | {4{external_trip_input_in}});
  wire next_hso = !blocking && high_speed_output;
  wire next_fcl = !blocking && current_sense_input_in &&
    (fcl || external_trip_input_in);
  wire trip_now = |next_rel || next_hso;

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trip_relay_1_out <= 1'b0;
      trip_relay_2_out <= 1'b0;
      trip_relay_3_out <= 1'b0;
      trip_relay_4_out <= 1'b0;
      high_speed_output_out <= 1'b0;
      fast_clear_output_out <= 1'b0;
      trip_indication_output_out <= 1'b0;
    end else begin
      trip_relay_1_out <= next_rel[0];
      trip_relay_2_out <= next_rel[1];
      trip_relay_3_out <= next_rel[2];
      trip_relay_4_out <= next_rel[3];
      high_speed_output_out <= next_hso;
      fast_clear_output_out <= next_fcl;
      if (trip_now) begin
        trip_indication_output_out <= 1'b1;
      end else if (ind_clear) begin
        trip_indication_output_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Non-volatile record store
  reg [1:0] nv_addr;
  reg [31:0] nv_wdata;
  reg nv_we;
  reg [1:0] nv_phase;
  reg [1:0] nv_load_slot;
  reg nv_loading;
  reg led_load;
  wire [31:0] nv_rdata;

  localparam NV_IDLE = 2'h0;
  localparam NV_WAIT = 2'h1;
  localparam NV_TAKE = 2'h2;

  atsm_nv_mem #(.WIDTH(32), .DEPTH(4), .AW(2)) u_nv (
    .ref_clk_in(ref_clk_in),
    .wr_en_in(nv_we),
    .addr_in(nv_addr),
    .wr_data_in(nv_wdata),
    .rd_data_out(nv_rdata)
  );

  atsm_led_latch #(.N(N_CH)) u_led (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .event_in(sensor_in),
    .clear_in(wr_hit(addr_in, `ATSM_REG_LED)),
    .load_in(led_load),
    .load_data_in(nv_rdata[N_CH-1:0]),
    .led_out(led)
  );

  wire save_cmd = wr_hit(addr_in, `ATSM_REG_NV_CMD) && wr_data_in[`ATSM_NV_CMD_SAVE];
  wire load_cmd = wr_hit(addr_in, `ATSM_REG_NV_CMD) && wr_data_in[`ATSM_NV_CMD_LOAD];
  reg [1:0] save_slot;
  reg nv_done;

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nv_phase <= NV_IDLE;
      nv_addr <= 2'h0;
      nv_wdata <= 32'h0;
      nv_we <= 1'b0;
      nv_load_slot <= 2'h0;
      nv_loading <= 1'b0;
      save_slot <= 2'h0;
      led_load <= 1'b0;
      nv_done <= 1'b0;
    end else begin
      nv_we <= 1'b0;
      led_load <= 1'b0;
      nv_done <= 1'b0;
      case (nv_phase)
        NV_IDLE: begin
          if (save_cmd) begin
            nv_loading <= 1'b0;
            save_slot <= `ATSM_NV_SLOT_CTRL;
            nv_phase <= NV_WAIT;
          end else if (load_cmd) begin
            nv_loading <= 1'b1;
            nv_addr <= `ATSM_NV_SLOT_CTRL;
            nv_phase <= NV_WAIT;
          end
        end
        NV_WAIT: begin
          if (nv_loading) begin
            nv_load_slot <= nv_addr;
            nv_phase <= NV_TAKE;
          end else begin
            nv_we <= 1'b1;
            nv_addr <= save_slot;
            nv_wdata <= (save_slot == `ATSM_NV_SLOT_CTRL) ? {27'h0, ctrl} :
              (save_slot == `ATSM_NV_SLOT_SETUP) ? setup : {17'h0, led};
            if (save_slot == `ATSM_NV_SLOT_LED) begin
              nv_done <= 1'b1;
              nv_phase <= NV_IDLE;
            end else begin
              save_slot <= save_slot + 2'h1;
            end
          end
        end
        NV_TAKE: begin
          led_load <= (nv_load_slot == `ATSM_NV_SLOT_LED);
          if (nv_load_slot == `ATSM_NV_SLOT_LED) begin
            nv_done <= 1'b1;
            nv_phase <= NV_IDLE;
          end else begin
            nv_addr <= nv_load_slot + 2'h1;
            nv_phase <= NV_WAIT;
          end
        end
        default: begin
          nv_phase <= NV_IDLE;
        end
      endcase
    end
  end

  wire take_ctrl = (nv_phase == NV_TAKE) && (nv_load_slot == `ATSM_NV_SLOT_CTRL);
  wire take_setup = (nv_phase == NV_TAKE) && (nv_load_slot == `ATSM_NV_SLOT_SETUP);

  ////////////////////////////////////////////////////////////////////////
  // Register port and interrupts
  wire [`ATSM_IRQ_W-1:0] irq_ev = {nv_done, |sensor_in, trip_now};
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl <= `ATSM_CTRL_RESET;
      setup <= 32'h0;
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
      ind_clear <= 1'b0;
      rd_data_out <= 32'h0;
      irq_out <= 1'b0;
    end else begin
      ind_clear <= wr_hit(addr_in, `ATSM_REG_STATUS) && wr_data_in[0];
      if (take_ctrl) begin
        ctrl <= nv_rdata[4:0];
      end else if (wr_hit(addr_in, `ATSM_REG_CTRL)) begin
        ctrl <= wr_data_in[4:0];
      end
      if (take_setup) begin
        setup <= nv_rdata;
      end else if (wr_hit(addr_in, `ATSM_REG_SETUP)) begin
        setup <= wr_data_in;
      end
      if (wr_hit(addr_in, `ATSM_REG_IRQ_MASK)) begin
        irq_mask <= wr_data_in[`ATSM_IRQ_W-1:0];
      end
      // Set wins over write-one clear
      irq_stat <= (irq_stat & ~(wr_hit(addr_in, `ATSM_REG_IRQ_STAT) ?
        wr_data_in[`ATSM_IRQ_W-1:0] : 3'h0)) | irq_ev;
      irq_out <= |(irq_stat & irq_mask);
      rd_data_out <= 32'h0;
      if (rd_en_in) begin
        case (addr_in)
          `ATSM_REG_CTRL: rd_data_out <= {27'h0, ctrl};
          `ATSM_REG_STATUS: rd_data_out <= {22'h0, nv_phase, trip_relay_4_out,
            trip_relay_3_out, trip_relay_2_out, trip_relay_1_out,
            fast_clear_output_out, high_speed_output_out,
            current_sense_input_in, trip_indication_output_out};
          `ATSM_REG_IRQ_STAT: rd_data_out <= {29'h0, irq_stat};
          `ATSM_REG_IRQ_MASK: rd_data_out <= {29'h0, irq_mask};
          `ATSM_REG_LED: rd_data_out <= {17'h0, led};
          `ATSM_REG_SETUP: rd_data_out <= setup;
          default: rd_data_out <= 32'h0;
        endcase
      end
    end
  end
endmodule

// ==== testbench/atsm_field_model.sv ====
/* Field side: light sensors, current measuring device, external trip contact.
   Assumes the bench commands each level just after a rising clock edge. */
module atsm_field_model (
  input wire [14:0] light_in,
  input wire amps_in,
  input wire ext_in,
  output wire [14:0] sensor_out,
  output wire current_out,
  output wire ext_trip_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sensor heads and contacts give clean levels
  assign sensor_out = light_in;
  assign current_out = amps_in;
  assign ext_trip_out = ext_in;
endmodule

// ==== testbench/atsm_top_props.sv ====
/* Port checker for the trip matrix.
   Assumes a bind onto atsm_top, everything on ref_clk_in. */
`include "atsm_regs.vh"
module atsm_top_props #(
  parameter N_CH = 15
) (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire [N_CH-1:0] sensor_in,
  input wire current_sense_input_in,
  input wire external_trip_input_in,
  input wire [`ATSM_ADDR_W-1:0] addr_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [`ATSM_DATA_W-1:0] rd_data_out,
  input wire trip_relay_1_out,
  input wire trip_relay_2_out,
  input wire trip_relay_3_out,
  input wire trip_relay_4_out,
  input wire high_speed_output_out,
  input wire fast_clear_output_out,
  input wire trip_indication_output_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  wire any_relay = trip_relay_1_out | trip_relay_2_out | trip_relay_3_out | trip_relay_4_out;
  wire cause = (|sensor_in) | external_trip_input_in;
  sequence s_bad_read;
    rd_en_in && addr_in > 4'h6;
  endsequence
  sequence s_ind_quiet;
    !wr_en_in ##1 !wr_en_in ##1 (trip_indication_output_out && !wr_en_in);
  endsequence
  a_read_idle_zero: assert property (!rd_en_in |=> rd_data_out == 32'h0)
    else $error("read data not zero outside a read");
  a_read_unmapped: assert property (s_bad_read |=> rd_data_out == 32'h0)
    else $error("unmapped read returned data");
  a_relay_needs_cause: assert property (any_relay |-> $past(cause))
    else $error("relay active without light or external trip");
  a_hso_needs_cause: assert property (high_speed_output_out |-> $past(cause))
    else $error("high-speed output without cause");
  property p_fcl_current;
    fast_clear_output_out |-> $past(current_sense_input_in);
  endproperty
  a_fcl_needs_current: assert property (p_fcl_current)
    else $error("fast clear without current");
  a_relay_sets_ind: assert property (any_relay |-> trip_indication_output_out)
    else $error("relay trip without indication");
  a_hso_sets_ind: assert property (high_speed_output_out |-> trip_indication_output_out)
    else $error("high-speed trip without indication");
  a_ind_stays_latched: assert property (s_ind_quiet |=> trip_indication_output_out)
    else $error("indication dropped without a clear");
endmodule
bind atsm_top atsm_top_props #(.N_CH(N_CH)) u_props (.ref_clk_in(ref_clk_in),
  .rstn_in(rstn_in), .sensor_in(sensor_in), .current_sense_input_in(current_sense_input_in),
  .external_trip_input_in(external_trip_input_in), .addr_in(addr_in), .wr_en_in(wr_en_in),
  .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .trip_relay_1_out(trip_relay_1_out),
  .trip_relay_2_out(trip_relay_2_out), .trip_relay_3_out(trip_relay_3_out),
  .trip_relay_4_out(trip_relay_4_out), .high_speed_output_out(high_speed_output_out),
  .fast_clear_output_out(fast_clear_output_out),
  .trip_indication_output_out(trip_indication_output_out));

// ==== testbench/atsm_top_tb.sv ====
/* Self-checking bench for the arc trip scheme matrix.
   Assumes design, field model and checker are compiled before it. */
`include "atsm_regs.vh"
module atsm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [14:0] light = 15'h0;
  logic amps = 1'b0;
  logic ext = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] d;
  wire [14:0] sensor;
  wire cur, xtrip, t1, t2, t3, t4, high_speed_output, fcl, ind, irq;
  wire [31:0] rdata;
  wire [31:0] outs = {26'h0, t1, t2, t3, t4, high_speed_output, fcl};
  int n_fail = 0;
  int n_compared = 0;
  always #2 ref_clk_in = ~ref_clk_in;
  atsm_field_model u_field (.light_in(light), .amps_in(amps), .ext_in(ext),
    .sensor_out(sensor), .current_out(cur), .ext_trip_out(xtrip));
  atsm_top #(.N_CH(15)) DUT (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .sensor_in(sensor),
    .current_sense_input_in(cur), .external_trip_input_in(xtrip), .addr_in(addr),
    .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata),
    .trip_relay_1_out(t1), .trip_relay_2_out(t2), .trip_relay_3_out(t3),
    .trip_relay_4_out(t4), .high_speed_output_out(high_speed_output), .fast_clear_output_out(fcl),
    .trip_indication_output_out(ind), .irq_out(irq));
  ////////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    wr_en <= 1'b1; addr <= a; wdata <= v;
    @(posedge ref_clk_in);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge ref_clk_in);
    rd_en <= 1'b1; addr <= a;
    @(posedge ref_clk_in);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task apply(input logic [14:0] l, input logic c, input logic e);
    @(posedge ref_clk_in);
    light <= l; amps <= c; ext <= e;
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask
  task nv_wait;
    for (int i = 0; i < 64; i++) begin
      rd(`ATSM_REG_STATUS);
      if (d[9:8] === 2'b00) return;
    end
    chk({30'h0, d[9:8]}, 32'h0);
    final_report;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(`ATSM_REG_CTRL); chk(d, 32'h0);
    wr(`ATSM_REG_CTRL, 32'h13); rd(`ATSM_REG_CTRL); chk(d, 32'h13);
    wr(4'he, 32'hffffffff); rd(4'he); chk(d, 32'h0);
    wr(`ATSM_REG_CTRL, 32'h0);
  endtask
  task t_scheme3;
    int ch[7] = '{0, 1, 2, 10, 11, 12, 14};
    logic [5:0] e[7] = '{6'h06, 6'h06, 6'h06, 6'h20, 6'h10, 6'h08, 6'h06};
    wr(`ATSM_REG_CTRL, {29'h0, `ATSM_SCHEME_3});
    for (int i = 0; i < 7; i++) begin
      apply(15'h1 << ch[i], 1'b1, 1'b0);
      chk(outs, {26'h0, e[i]});
    end
    apply(15'h0, 1'b1, 1'b1);
    chk(outs & 32'h3c, 32'h3c);
  endtask
  task t_scheme4;
    int ch[6] = '{0, 10, 11, 12, 13, 14};
    logic [5:0] e[6] = '{6'h3e, 6'h20, 6'h10, 6'h08, 6'h04, 6'h3e};
    wr(`ATSM_REG_CTRL, {29'h0, `ATSM_SCHEME_4});
    for (int i = 0; i < 6; i++) begin
      apply(15'h1 << ch[i], 1'b1, 1'b0);
      chk(outs, {26'h0, e[i]});
    end
  endtask
  task t_scheme12;
    int ch[4] = '{0, 4, 6, 13};
    logic [5:0] e1[4] = '{6'h3e, 6'h3e, 6'h3f, 6'h3f};
    logic [5:0] e2[4] = '{6'h32, 6'h2a, 6'h2b, 6'h2f};
    wr(`ATSM_REG_CTRL, {29'h0, `ATSM_SCHEME_1});
    for (int i = 0; i < 4; i++) begin
      apply(15'h1 << ch[i], 1'b1, 1'b0);
      chk(outs, {26'h0, e1[i]});
    end
    wr(`ATSM_REG_CTRL, 32'h9);
    apply(15'h40, 1'b0, 1'b0);
    chk(outs, 32'h3e);
    wr(`ATSM_REG_CTRL, {29'h0, `ATSM_SCHEME_2});
    for (int i = 0; i < 4; i++) begin
      apply(15'h1 << ch[i], 1'b1, 1'b0);
      chk(outs, {26'h0, e2[i]});
    end
    wr(`ATSM_REG_CTRL, 32'h5);
    apply(15'h1, 1'b1, 1'b0);
    chk(outs, 32'h0);
  endtask
  task t_criterion;
    wr(`ATSM_REG_CTRL, 32'h0);
    apply(15'h1, 1'b0, 1'b0); chk(outs, 32'h0);
    apply(15'h1, 1'b1, 1'b0); chk(outs, 32'h3f);
    wr(`ATSM_REG_CTRL, 32'h8);
    apply(15'h1, 1'b0, 1'b0); chk(outs, 32'h3e);
    apply(15'h10, 1'b1, 1'b0); chk(outs, 32'h3e);
    wr(`ATSM_REG_CTRL, 32'h0);
    apply(15'h0, 1'b1, 1'b1); chk(outs & 32'h3d, 32'h3d);
  endtask
  task t_block;
    apply(15'h0, 1'b0, 1'b0);
    wr(`ATSM_REG_LED, 32'h0); wr(`ATSM_REG_CTRL, 32'h10);
    apply(15'h4, 1'b1, 1'b1); chk(outs, 32'h0);
    rd(`ATSM_REG_LED); chk(d & 32'h4, 32'h4);
    apply(15'h0, 1'b0, 1'b0); wr(`ATSM_REG_CTRL, 32'h0);
  endtask
  task t_irq;
    wr(`ATSM_REG_STATUS, 32'h1); wr(`ATSM_REG_IRQ_STAT, 32'h7); wr(`ATSM_REG_IRQ_MASK, 32'h0);
    repeat (3) @(posedge ref_clk_in);
    #1 chk({31'h0, ind}, 32'h0);
    apply(15'h400, 1'b1, 1'b0); apply(15'h0, 1'b0, 1'b0);
    chk({31'h0, ind}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(`ATSM_REG_IRQ_STAT); chk(d & 32'h1, 32'h1);
    wr(`ATSM_REG_IRQ_MASK, 32'h1); repeat (3) @(posedge ref_clk_in);
    #1 chk({31'h0, irq}, 32'h1);
    wr(`ATSM_REG_IRQ_STAT, 32'h1); repeat (3) @(posedge ref_clk_in);
    #1 chk({31'h0, irq}, 32'h0);
    wr(`ATSM_REG_IRQ_MASK, 32'h0);
  endtask
  task t_nv;
    wr(`ATSM_REG_CTRL, 32'h0b); wr(`ATSM_REG_SETUP, 32'h5a5a0f0f);
    wr(`ATSM_REG_LED, 32'h0);
    apply(15'h10, 1'b0, 1'b0); apply(15'h0, 1'b0, 1'b0);
    wr(`ATSM_REG_NV_CMD, 32'h1); nv_wait;
    // Power loss stand-in: registers drop, store keeps its records
    @(posedge ref_clk_in) rstn_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    rd(`ATSM_REG_CTRL); chk(d, 32'h0);
    wr(`ATSM_REG_NV_CMD, 32'h2); nv_wait;
    rd(`ATSM_REG_CTRL); chk(d, 32'h0b);
    rd(`ATSM_REG_SETUP); chk(d, 32'h5a5a0f0f);
    rd(`ATSM_REG_LED); chk(d, 32'h10);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    t_regs;
    t_scheme3;
    t_scheme4;
    t_scheme12;
    t_criterion;
    t_block;
    t_irq;
    t_nv;
    final_report;
  end
endmodule
